// ### src/sxp_pkg.sv
// shared constants, carrier structs and enumerations of the bus expander core
// assumes one core clock at CLK_HZ; pin levels already decoded to logical assertion-high
package sxp_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int DW = 16;
    localparam int NEX_AW = 8;

    // mode persistence, opposite-segment reset width, strobe reference switch delay
    localparam int MODE_STABLE_MS = 100;
    localparam int MODE_STABLE_CYC = MODE_STABLE_MS * (CLK_HZ / 1000);
    localparam int BUS_RST_US = 25;
    localparam int BUS_RST_CYC = BUS_RST_US * (CLK_HZ / 1_000_000);
    localparam int SWITCH_NS = 600;
    localparam int SWITCH_CYC = (SWITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // bus phase code {msg, cd, io}: top two bits
    localparam logic [1:0] PH_DATA = 2'h0;
    localparam logic [1:0] PH_MSG = 2'h3;

    // message bytes
    localparam logic [7:0] MSG_EXT = 8'h01;
    localparam logic [7:0] EXT_SDTR = 8'h01;
    localparam logic [7:0] EXT_WDTR = 8'h03;
    localparam logic [7:0] EXT_PPR = 8'h04;
    localparam logic [7:0] PF_U320 = 8'h08;
    localparam logic [7:0] PF_ULTRA = 8'h0C;
    localparam logic [2:0] ARG_MAX = 3'h4;

    typedef enum logic [1:0] {MODE_SE, MODE_LVD, MODE_HVD} sxp_mode_t;
    typedef enum logic [1:0] {NG_IDLE, NG_LEN, NG_CODE, NG_ARGS} sxp_nego_t;

    typedef struct packed {
        logic req;
        logic ack;
        logic p1;
        logic [1:0] par;
        logic [DW-1:0] data;
    } sxp_side_in_t;

    typedef struct packed {
        logic req;
        logic req_oe;
        logic ack;
        logic ack_oe;
        logic p1;
        logic [1:0] par;
        logic [DW-1:0] data;
        logic data_oe;
        logic [DW+3:0] full_drv;
        logic plus_gnd;
        logic rst_o;
        logic rst_oe;
    } sxp_side_out_t;

    typedef struct packed {
        logic [2:0] phase;
        logic [3:0] init_id;
        logic [3:0] targ_id;
        logic connect;
        logic init_on_b;
        logic train_done;
        logic [7:0] skew_adj;
    } sxp_ctl_t;

    typedef struct packed {
        logic [7:0] period;
        logic [7:0] offset;
        logic [7:0] width;
        logic [7:0] skew;
    } sxp_entry_t;

    localparam sxp_entry_t ENTRY_DEF = '{period: PF_ULTRA, offset: 8'h00, width: 8'h00,
                                         skew: 8'h00};

    typedef struct packed {
        sxp_mode_t mode_a;
        sxp_mode_t mode_b;
        logic dt_en;
        logic paced;
        logic xfer_done;
        logic xfer_ok;
        logic data_valid;
        logic p1_err;
        logic ref_req;
        logic [7:0] rate;
        logic [7:0] offset;
        logic [7:0] width;
        logic [7:0] skew;
    } sxp_stat_t;

endpackage

// ### src/sxp_nexus_ram.sv
// per-nexus negotiation and skew table storage
// assumes the owner keeps a separate valid bit per entry; contents are not reset
module sxp_nexus_ram #(
    parameter int AW = 8,
    parameter int W = 32
) (
    input logic CLK,
    input logic WE,
    input logic [AW-1:0] WADDR,
    input logic [W-1:0] WDATA,
    input logic [AW-1:0] RADDR,
    output logic [W-1:0] RDATA
);

    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge CLK) begin
        if (WE) begin
            mem[WADDR] <= WDATA;
        end
        RDATA <= mem[RADDR];
    end

endmodule

// ### src/sxp_expander.sv
// expander core: mode sensing, strobe forwarding, data forwarding in data phases only, paced transfer tracking,
// negotiation snooping into a per-nexus table
// assumes bus pins arrive asynchronously and are synchronised here; one core clock
module sxp_expander
    import sxp_pkg::*;
#(
    parameter int MODE_CYC = MODE_STABLE_CYC
) (
    input logic CLK,
    input logic ARST_N,
    input sxp_pkg::sxp_side_in_t A_IN,
    input sxp_pkg::sxp_side_in_t B_IN,
    input sxp_pkg::sxp_ctl_t CTL,
    input logic [1:0] SIDE_A_MODE_SENSE,
    input logic [1:0] SIDE_B_MODE_SENSE,
    output sxp_pkg::sxp_side_out_t A_OUT,
    output sxp_pkg::sxp_side_out_t B_OUT,
    output sxp_pkg::sxp_stat_t STATUS
);
    import sxp_pkg::*;

    localparam int MCW = $clog2(MODE_CYC + 1);
    localparam int RCW = $clog2(BUS_RST_CYC + 1);
    localparam int SCW = $clog2(SWITCH_CYC + 1);

    typedef struct packed {
        sxp_side_in_t a1, a2, a3, b1, b2, b3;
        sxp_ctl_t c1, c2, c3;
        logic [1:0][1:0] m1, m2;
        sxp_mode_t [1:0] mode;
        sxp_mode_t [1:0] cand;
        logic [1:0][MCW-1:0] mcnt;
        logic [1:0][RCW-1:0] rcnt;
        logic ref_req;
        logic quiet;
        logic [SCW-1:0] qcnt;
        logic paced_run;
        logic [15:0] req_cnt;
        logic [15:0] ack_cnt;
        logic cnt_par;
        logic ph_set;
        logic ph_ref;
        logic p1_last;
        logic inv_tog;
        logic [DW-1:0] dq;
        logic [1:0] pq;
        logic [DW+3:0] full;
        sxp_nego_t nst;
        logic [7:0] mlen;
        logic [7:0] mcode;
        logic [2:0] aidx;
        logic [3:0][7:0] args;
        logic [(1<<NEX_AW)-1:0] nvalid;
        logic we;
        logic [NEX_AW-1:0] waddr;
        sxp_entry_t wdata;
        sxp_side_out_t oa, ob;
        sxp_stat_t st;
    } sxp_state_t;

    localparam sxp_state_t ST_RST = '0;

    sxp_state_t r, n;
    sxp_entry_t cur;
    logic [NEX_AW-1:0] nex;

    function automatic logic edge_of(input logic now, input logic prev);
        return now ^ prev;
    endfunction

    assign nex = {r.c2.init_id, r.c2.targ_id};

    sxp_nexus_ram #(.AW(NEX_AW), .W($bits(sxp_entry_t))) u_table (
        .CLK(CLK),
        .WE(r.we),
        .WADDR(r.waddr),
        .WDATA(r.wdata),
        .RADDR(nex),
        .RDATA(cur)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        sxp_side_in_t si, sip, st_, stp, src, srcp;
        sxp_side_out_t oi, ot;
        sxp_entry_t ent;
        logic [3:0][7:0] la;
        logic [2:0] ph;
        logic hvd, dt_ok, dphase, cvalid, paced, drive;
        logic ack_e, req_e, sel_e, sel_rise, take, end_now, ph_now, v;
        logic [7:0] byt;
        si = '0;
        sip = '0;
        st_ = '0;
        stp = '0;
        src = '0;
        srcp = '0;
        oi = '0;
        ot = '0;
        ent = '0;
        la = '0;
        ph = '0;
        hvd = 1'b0;
        dt_ok = 1'b0;
        dphase = 1'b0;
        cvalid = 1'b0;
        paced = 1'b0;
        drive = 1'b0;
        ack_e = 1'b0;
        req_e = 1'b0;
        sel_e = 1'b0;
        sel_rise = 1'b0;
        take = 1'b0;
        end_now = 1'b0;
        ph_now = 1'b0;
        v = 1'b0;
        byt = '0;
        n = r;
        n.we = 1'b0;
        n.st.xfer_done = 1'b0;

        // pin synchronisers
        n.a1 = A_IN;
        n.a2 = r.a1;
        n.a3 = r.a2;
        n.b1 = B_IN;
        n.b2 = r.b1;
        n.b3 = r.b2;
        n.c1 = CTL;
        n.c2 = r.c1;
        n.c3 = r.c2;
        n.m1 = {SIDE_B_MODE_SENSE, SIDE_A_MODE_SENSE};
        n.m2 = r.m1;

        // mode persistence per side, counted on the core clock
        for (int i = 0; i < 2; i++) begin
            if (r.rcnt[i] != '0) begin
                n.rcnt[i] = r.rcnt[i] - 1'b1;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (r.m2[i] != r.cand[i]) begin
                n.cand[i] = sxp_mode_t'(r.m2[i]);
                n.mcnt[i] = '0;
            end else if (r.cand[i] != r.mode[i]) begin
                if (r.mcnt[i] == MCW'(MODE_CYC - 1)) begin
                    n.mode[i] = r.cand[i];
                    n.mcnt[i] = '0;
                    n.rcnt[1-i] = RCW'(BUS_RST_CYC);
                end else begin
                    n.mcnt[i] = r.mcnt[i] + 1'b1;
                end
            end else begin
                n.mcnt[i] = '0;
            end
        end
        hvd = (r.mode[0] == MODE_HVD) || (r.mode[1] == MODE_HVD);
        dt_ok = (r.mode[0] == MODE_LVD) && (r.mode[1] == MODE_LVD);

        // initiator/target side views
        si = r.c2.init_on_b ? r.b2 : r.a2;
        sip = r.c2.init_on_b ? r.b3 : r.a3;
        st_ = r.c2.init_on_b ? r.a2 : r.b2;
        stp = r.c2.init_on_b ? r.a3 : r.b3;
        ph = r.c2.phase;
        dphase = (ph[2:1] == PH_DATA);
        src = ph[0] ? st_ : si;
        srcp = ph[0] ? stp : sip;
        cvalid = r.nvalid[nex];
        paced = dt_ok && cvalid && (cur.period == PF_U320) && (cur.offset != '0);
        ack_e = edge_of(si.ack, sip.ack);
        req_e = edge_of(st_.req, stp.req);
        sel_e = r.ref_req ? req_e : ack_e;
        sel_rise = sel_e && (r.ref_req ? st_.req : si.ack);

        // retiming reference: ACK in data-out, REQ after the paced quiet window
        if (dphase && !ph[0]) begin
            n.ref_req = 1'b0;
            n.quiet = 1'b0;
        end else if (!r.ref_req) begin
            if (!r.paced_run) begin
                n.ref_req = 1'b1;
            end else if (!r.quiet) begin
                n.quiet = 1'b1;
                n.qcnt = SCW'(SWITCH_CYC - 1);
            end else if (r.qcnt == '0) begin
                n.ref_req = 1'b1;
                n.quiet = 1'b0;
                end_now = 1'b1;
            end else begin
                n.qcnt = r.qcnt - 1'b1;
            end
        end else if (r.paced_run && !dphase) begin
            end_now = 1'b1;
        end

        // paced transfer bookkeeping
        if (!r.paced_run && paced && dphase) begin
            n.paced_run = 1'b1;
            n.req_cnt = '0;
            n.ack_cnt = '0;
            n.ph_set = 1'b0;
            n.cnt_par = 1'b0;
        end else if (r.paced_run) begin
            if (req_e) begin
                n.req_cnt = r.req_cnt + 1'b1;
            end
            if (ack_e) begin
                n.ack_cnt = r.ack_cnt + 1'b1;
            end
        end
        if (end_now) begin
            n.paced_run = 1'b0;
            n.st.xfer_done = 1'b1;
            n.st.xfer_ok = (r.req_cnt == r.ack_cnt) && !st_.req && !si.ack;
        end

        // data capture; CRC words take the same path as data
        take = !r.quiet && dphase && (dt_ok ? sel_e : sel_rise);
        if (take) begin
            n.dq = src.data;
            n.pq = src.par;
            n.full = r.paced_run ? {2'b11, {src.par, src.data} ^ {r.pq, r.dq}} : '1;
        end

        // valid-phase decode at strobe assertions
        if (r.paced_run && sel_rise && !r.quiet) begin
            ph_now = src.p1 ^ r.cnt_par;
            n.cnt_par = ~r.cnt_par;
            n.p1_last = src.p1;
            if (!r.ph_set) begin
                n.ph_set = 1'b1;
                n.ph_ref = ph_now;
                n.st.data_valid = 1'b1;
            end else begin
                v = (ph_now == r.ph_ref);
                if (!v && r.st.data_valid) begin
                    n.inv_tog = 1'b0;
                end else if (!v && (src.p1 != r.p1_last)) begin
                    n.inv_tog = 1'b1;
                end
                if (v && !r.st.data_valid && !r.inv_tog) begin
                    n.st.p1_err = 1'b1;
                end
                n.st.data_valid = v;
            end
        end

        // negotiation snoop on ACK assertion in message phases
        byt = ph[0] ? st_.data[7:0] : si.data[7:0];
        la = r.args;
        ent = cvalid ? cur : ENTRY_DEF;
        if (ph[2:1] != PH_MSG) begin
            n.nst = NG_IDLE;
        end else if (ack_e && si.ack) begin
            case (r.nst)
                NG_IDLE: begin
                    if (byt == MSG_EXT) begin
                        n.nst = NG_LEN;
                    end
                end
                NG_LEN: begin
                    n.mlen = byt;
                    n.nst = NG_CODE;
                end
                NG_CODE: begin
                    n.mcode = byt;
                    n.aidx = '0;
                    n.nst = (r.mlen > 8'h01) ? NG_ARGS : NG_IDLE;
                end
                NG_ARGS: begin
                    if (r.aidx < ARG_MAX) begin
                        la[r.aidx[1:0]] = byt;
                    end
                    n.args = la;
                    n.aidx = r.aidx + 1'b1;
                    if ({5'h00, r.aidx} == r.mlen - 8'h02) begin
                        n.nst = NG_IDLE;
                        case (r.mcode)
                            EXT_SDTR: begin
                                ent.period = la[0];
                                ent.offset = la[1];
                            end
                            EXT_WDTR: begin
                                ent.width = la[0];
                            end
                            EXT_PPR: begin
                                ent.period = la[0];
                                ent.offset = la[2];
                                ent.width = la[3];
                            end
                            default: begin
                            end
                        endcase
                        // one agreement serves the initiator side and the target side
                        n.we = 1'b1;
                        n.waddr = nex;
                        n.wdata = ent;
                        n.nvalid[nex] = 1'b1;
                    end
                end
                default: begin
                    n.nst = NG_IDLE;
                end
            endcase
        end else if (r.c2.train_done && !r.c3.train_done && paced) begin
            ent.skew = r.c2.skew_adj;
            n.we = 1'b1;
            n.waddr = nex;
            n.wdata = ent;
        end

        // outputs: strobes leave in the same cycle as the data captured on them
        drive = r.c2.connect && !hvd;
        oi.req = stp.req & ~r.quiet;
        oi.req_oe = drive;
        ot.ack = sip.ack & ~r.quiet;
        ot.ack_oe = drive;
        if (ph[0]) begin
            oi.data = r.dq;
            oi.par = r.pq;
            oi.p1 = srcp.p1;
            oi.data_oe = drive;
            oi.full_drv = r.full;
        end else begin
            ot.data = r.dq;
            ot.par = r.pq;
            ot.p1 = srcp.p1;
            ot.data_oe = drive;
            ot.full_drv = r.full;
        end
        n.oa = r.c2.init_on_b ? ot : oi;
        n.ob = r.c2.init_on_b ? oi : ot;
        n.oa.plus_gnd = (r.mode[0] == MODE_SE);
        n.ob.plus_gnd = (r.mode[1] == MODE_SE);
        n.oa.rst_oe = (r.rcnt[0] != '0) && !hvd;
        n.ob.rst_oe = (r.rcnt[1] != '0) && !hvd;

        n.st.mode_a = r.mode[0];
        n.st.mode_b = r.mode[1];
        n.st.dt_en = dt_ok;
        n.st.paced = paced;
        n.st.ref_req = r.ref_req;
        n.st.rate = cvalid ? cur.period : PF_ULTRA;
        n.st.offset = cvalid ? cur.offset : 8'h00;
        n.st.width = cvalid ? cur.width : 8'h00;
        n.st.skew = paced ? cur.skew : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= ST_RST;
        end else begin
            r <= n;
        end
    end

    assign A_OUT = r.oa;
    assign B_OUT = r.ob;
    assign STATUS = r.st;

endmodule

// ### tb/sxp_expander_checker.sv
// port-level relations of the expander core over time
// assumes binding into sxp_expander; everything in the CLK domain
module sxp_expander_checker
    import sxp_pkg::*;
#(
    parameter int MODE_CYC = MODE_STABLE_CYC
) (
    input logic CLK,
    input logic ARST_N,
    input logic [1:0] SIDE_A_MODE_SENSE,
    input logic [1:0] SIDE_B_MODE_SENSE,
    input sxp_pkg::sxp_side_out_t A_OUT,
    input sxp_pkg::sxp_side_out_t B_OUT,
    input sxp_pkg::sxp_stat_t STATUS
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    ////////////////////////////////////////////////////////////////////////////////
    int stab_a;
    int stab_b;
    int quiet;
    logic [1:0] sa_q;
    logic [1:0] sb_q;
    wire hvd = STATUS.mode_a == MODE_HVD || STATUS.mode_b == MODE_HVD;
    wire any_oe = |{A_OUT.req_oe, A_OUT.ack_oe, A_OUT.data_oe, A_OUT.rst_oe,
                    B_OUT.req_oe, B_OUT.ack_oe, B_OUT.data_oe, B_OUT.rst_oe};
    wire strobes = A_OUT.req | A_OUT.ack | B_OUT.req | B_OUT.ack;
    // consecutive cycles of unchanged sense, and of quiet output strobes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stab_a <= 0;
            stab_b <= 0;
            quiet <= 0;
            sa_q <= 2'h0;
            sb_q <= 2'h0;
        end else begin
            sa_q <= SIDE_A_MODE_SENSE;
            sb_q <= SIDE_B_MODE_SENSE;
            stab_a <= (SIDE_A_MODE_SENSE != sa_q) ? 0 : (stab_a < 100000 ? stab_a + 1 : stab_a);
            stab_b <= (SIDE_B_MODE_SENSE != sb_q) ? 0 : (stab_b < 100000 ? stab_b + 1 : stab_b);
            quiet <= strobes ? 0 : (quiet < 1000 ? quiet + 1 : quiet);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence rst_held(logic s);
        s [*8];
    endsequence
    sequence mode_moved(sxp_mode_t m, sxp_mode_t o);
        $changed(m) && m != MODE_HVD && o != MODE_HVD;
    endsequence
    a_mode_persist_a: assert property ($changed(STATUS.mode_a) |->
        stab_a >= MODE_CYC && STATUS.mode_a == SIDE_A_MODE_SENSE)
        else $error("side A mode switched without persisted sense");
    a_mode_persist_b: assert property ($changed(STATUS.mode_b) |->
        stab_b >= MODE_CYC && STATUS.mode_b == SIDE_B_MODE_SENSE)
        else $error("side B mode switched without persisted sense");
    a_opp_reset_b: assert property (mode_moved(STATUS.mode_a, STATUS.mode_b) |=>
        rst_held(B_OUT.rst_oe)) else $error("no bus reset on side B after side A mode change");
    a_opp_reset_a: assert property (mode_moved(STATUS.mode_b, STATUS.mode_a) |=>
        rst_held(A_OUT.rst_oe)) else $error("no bus reset on side A after side B mode change");
    a_hvd_all_off: assert property (hvd && $past(hvd) |-> !any_oe)
        else $error("output enabled while a side is high-voltage differential");
    // the first edge after release still shows the all-zero reset outputs
    a_se_plus_gnd: assert property (STATUS.mode_a == MODE_SE &&
        $past(STATUS.mode_a) == MODE_SE && $past(ARST_N) |-> A_OUT.plus_gnd)
        else $error("plus line not grounded");
    a_lvd_pair_used: assert property (STATUS.mode_a == MODE_LVD &&
        $past(STATUS.mode_a) == MODE_LVD |-> !A_OUT.plus_gnd) else $error("plus line grounded");
    a_dt_lvd_only: assert property (STATUS.dt_en && $stable(STATUS.mode_a) &&
        $stable(STATUS.mode_b) |-> STATUS.mode_a == MODE_LVD && STATUS.mode_b == MODE_LVD)
        else $error("double-edge clocking outside LVD");
    a_paced_top_rate: assert property (STATUS.paced && $stable(STATUS.rate) &&
        $stable(STATUS.offset) |-> STATUS.rate == PF_U320 && STATUS.offset != 8'h00)
        else $error("paced without top-rate agreement");
    a_ref_after_quiet: assert property ($rose(STATUS.ref_req) |-> quiet >= 50)
        else $error("reference moved without a quiet strobe window");
    a_done_one_cycle: assert property (STATUS.xfer_done |=> !STATUS.xfer_done)
        else $error("transfer done longer than one cycle");
    a_ok_at_done: assert property ($changed(STATUS.xfer_ok) |-> STATUS.xfer_done)
        else $error("transfer result changed outside done");
endmodule

// ### tb/sxp_scsi_peer.sv
// paced data source standing for an initiator or target on one segment
// assumes go is pulsed only while busy is low; strobe stands still between frames
module sxp_scsi_peer #(
    parameter int HALF_NS = 80
) (
    input logic go,
    input logic [7:0] edges,
    input logic pause,
    output logic strb,
    output logic p1,
    output logic [15:0] data,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        strb = 1'b0;
        p1 = 1'b0;
        data = 16'h0000;
        busy = 1'b0;
    end
    always @(posedge go) begin
        busy = 1'b1;
        for (int k = 0; k < int'(edges); k++) begin
            #HALF_NS;
            strb = ~strb;
            data = 16'(k + 1);
            // phase held two periods, then toggled on assertions only; a pause withholds
            // the toggles at the fourth and sixth assertion: two invalid periods, one toggle
            if (strb && k >= 2 && !(pause && (k == 6 || k == 10))) begin
                p1 = ~p1;
            end
        end
        #HALF_NS;
        data = 16'h0000;
        busy = 1'b0;
    end
endmodule

// ### tb/sxp_expander_test.sv
// self-checking bench of the expander core with two paced peers
// assumes a shortened mode persistence count; peers run on their own 160 ns strobe
module sxp_expander_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sxp_pkg::*;
    localparam int MC = 50;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [1:0] sense_a = 2'h0;
    logic [1:0] sense_b = 2'h0;
    sxp_ctl_t ctl = '0;
    logic m_ack = 1'b0;
    logic [15:0] m_data = 16'h0000;
    logic pa_go = 1'b0;
    logic pb_go = 1'b0;
    logic [7:0] pb_n = 8'h10;
    logic pa_strb, pa_p1, pa_busy, pb_strb, pb_p1, pb_busy;
    logic [15:0] pa_data, pb_data;
    sxp_side_in_t a_in, b_in;
    sxp_side_out_t a_out, b_out;
    sxp_stat_t stat;
    logic ack_q = 1'b0;
    int ack_cnt = 0;
    logic pa_pause = 1'b0;
    logic dv_q = 1'b0;
    int dv_fall = 0;
    int mismatches = 0;
    int samples_checked = 0;
    assign a_in = '{req: 1'b0, ack: pa_strb | m_ack, p1: pa_p1, par: 2'h0, data: pa_data | m_data};
    assign b_in = '{req: pb_strb, ack: 1'b0, p1: pb_p1, par: 2'h0, data: pb_data};
    sxp_expander #(.MODE_CYC(MC)) dut (.CLK(CLK), .ARST_N(ARST_N), .A_IN(a_in), .B_IN(b_in),
        .CTL(ctl), .SIDE_A_MODE_SENSE(sense_a), .SIDE_B_MODE_SENSE(sense_b), .A_OUT(a_out),
        .B_OUT(b_out), .STATUS(stat));
    sxp_scsi_peer u_pa (.go(pa_go), .edges(8'h10), .pause(pa_pause), .strb(pa_strb), .p1(pa_p1),
        .data(pa_data), .busy(pa_busy));
    sxp_scsi_peer u_pb (.go(pb_go), .edges(pb_n), .pause(1'b0), .strb(pb_strb), .p1(pb_p1),
        .data(pb_data), .busy(pb_busy));
    initial begin
        forever #5 CLK = ~CLK;
    end
    // forwarded strobe edges on the load side and valid-state drops, off the launching edge
    always @(negedge CLK) begin
        ack_q <= b_out.ack;
        dv_q <= stat.data_valid;
        if (b_out.ack !== ack_q) ack_cnt <= ack_cnt + 1;
        if (dv_q === 1'b1 && stat.data_valid === 1'b0) dv_fall <= dv_fall + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task check_w(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tmo(input int i, input int lim);
        if (i >= lim) begin
            mismatches++;
            $display("CHECK FAILED t=%0t wait=%h bound=%h", $time, i, lim);
            end_of_test();
        end
    endtask
    task send_byte(input logic [7:0] b);
        m_data = {8'h00, b};
        repeat (4) @(negedge CLK);
        m_ack = 1'b1;
        repeat (4) @(negedge CLK);
        m_ack = 1'b0;
        repeat (4) @(negedge CLK);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        @(negedge CLK);
        check_bit(a_out.plus_gnd, 1'b1);
        check_w(stat.rate, PF_ULTRA);
        check_bit(b_out.rst_oe, 1'b0);
    endtask
    task t_mode;
        int i;
        sense_a = 2'h1;
        repeat (30) @(negedge CLK);
        sense_a = 2'h0;
        @(negedge CLK);
        sense_a = 2'h1;
        for (i = 0; i < 400 && stat.mode_a !== MODE_LVD; i++) @(negedge CLK);
        tmo(i, 400);
        check_bit(i >= MC, 1'b1);
        repeat (3) @(negedge CLK);
        check_bit(b_out.rst_oe, 1'b1);
        check_bit(a_out.plus_gnd, 1'b0);
        sense_b = 2'h1;
        for (i = 0; i < 400 && stat.mode_b !== MODE_LVD; i++) @(negedge CLK);
        tmo(i, 400);
        repeat (3) @(negedge CLK);
        check_bit(a_out.rst_oe, 1'b1);
        check_bit(stat.dt_en, 1'b1);
    endtask
    task t_nego;
        logic [7:0] ppr [8];
        ppr = '{MSG_EXT, 8'h06, EXT_PPR, PF_U320, 8'h00, 8'h10, 8'h01, 8'h00};
        ctl.connect = 1'b1;
        ctl.init_id = 4'h7;
        ctl.phase = 3'h6;
        repeat (10) @(negedge CLK);
        for (int k = 0; k < 8; k++) send_byte(ppr[k]);
        repeat (10) @(negedge CLK);
        check_w(stat.rate, PF_U320);
        check_w(stat.offset, 8'h10);
        ctl.skew_adj = 8'h5A;
        ctl.train_done = 1'b1;
        repeat (10) @(negedge CLK);
        check_w(stat.skew, 8'h5A);
    endtask
    task t_xfer(input logic [7:0] nb, input logic ok, input logic pz);
        int i;
        int base_a;
        int base_v;
        ctl.phase = 3'h0;
        pb_n = nb;
        pa_pause = pz;
        repeat (10) @(negedge CLK);
        check_bit(stat.paced, 1'b1);
        base_a = ack_cnt;
        base_v = dv_fall;
        pa_go = 1'b1;
        pb_go = 1'b1;
        @(negedge CLK);
        pa_go = 1'b0;
        pb_go = 1'b0;
        for (i = 0; i < 400 && (pa_busy === 1'b1 || pb_busy === 1'b1); i++) @(negedge CLK);
        tmo(i, 400);
        repeat (10) @(negedge CLK);
        check_w(ack_cnt - base_a, 32'h10);
        check_w(b_out.data, 16'h0010);
        check_w(b_out.full_drv, 32'h000C001F);
        check_bit(stat.data_valid, 1'b1);
        check_w(dv_fall - base_v, {31'h0, pz});
        check_bit(stat.p1_err, 1'b0);
        ctl.phase = 3'h3;
        for (i = 0; i < 200 && stat.xfer_done !== 1'b1; i++) @(negedge CLK);
        tmo(i, 200);
        check_bit(i >= 58, 1'b1);
        check_bit(stat.xfer_ok, ok);
        repeat (2) @(negedge CLK);
        check_bit(stat.ref_req, 1'b1);
        repeat (80) @(negedge CLK);
    endtask
    task t_hvd;
        int i;
        sense_a = 2'h2;
        for (i = 0; i < 400 && stat.mode_a !== MODE_HVD; i++) @(negedge CLK);
        tmo(i, 400);
        repeat (3) @(negedge CLK);
        check_w({a_out.req_oe, a_out.ack_oe, a_out.data_oe, a_out.rst_oe, b_out.req_oe,
            b_out.ack_oe, b_out.data_oe, b_out.rst_oe}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge CLK);
        ARST_N = 1'b1;
        t_reset();
        t_mode();
        t_nego();
        t_xfer(8'h10, 1'b1, 1'b0);
        t_xfer(8'h0F, 1'b0, 1'b1);
        t_hvd();
        end_of_test();
    end
endmodule

bind sxp_expander sxp_expander_checker #(.MODE_CYC(MODE_CYC)) u_chk (.CLK(CLK), .ARST_N(ARST_N),
    .SIDE_A_MODE_SENSE(SIDE_A_MODE_SENSE), .SIDE_B_MODE_SENSE(SIDE_B_MODE_SENSE),
    .A_OUT(A_OUT), .B_OUT(B_OUT), .STATUS(STATUS));
